// ==== rtl/perc_top.v ====
// Per-port error management bank: error rate enable, attribute
// capture with lock, error detect status and interrupt.
// Assumes error events are one-cycle pulses from logic on mclk_i,
// with capture information valid in the same cycle, and an APB
// master on the same clock; capture data registers and the rate
// counter sit outside and follow capture_load_o and rate_inc_o.
`timescale 1ns/100ps
`default_nettype none
`include "perc_regs.vh"

module perc_top (
   input  wire                     mclk_i,
   input  wire                     rstn_i,
   // APB slave
   input  wire [23:0]              paddr_i,
   input  wire                     psel_i,
   input  wire                     penable_i,
   input  wire                     pwrite_i,
   input  wire [31:0]              pwdata_i,
   output wire [31:0]              prdata_o,
   output wire                     pready_o,
   output wire                     pslverr_o,
   // Error events from the link logic
   input  wire [31:0]              err_event_i,
   input  wire [2:0]               cap_info_type_i,
   input  wire [19:0]              cap_impl_i,
   // Results
   output wire                     rate_inc_o,
   output wire [31:0]              rate_hits_o,
   output wire                     capture_lock_o,
   output wire                     capture_load_o,
   output wire                     irq_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg  [31:0]                     rate_en;
   reg  [2:0]                      info_type;
   reg  [4:0]                      err_type;
   reg  [19:0]                     impl_info;
   reg                             capt_valid;
   reg  [31:0]                     err_detect;
   reg  [31:0]                     irq_en;
   reg  [31:0]                     rd_data;
   reg                             rate_inc;
   reg  [31:0]                     rate_hits;
   reg                             capture_load;
   reg                             irq;

   reg  [31:0]                     next_rd_data;
   reg  [31:0]                     next_rate_en;
   reg                             next_rate_inc;
   reg  [31:0]                     next_rate_hits;
   reg  [2:0]                      next_info_type;
   reg  [4:0]                      next_err_type;
   reg  [19:0]                     next_impl_info;
   reg                             next_capt_valid;
   reg                             next_capture_load;
   reg  [31:0]                     next_irq_en;
   reg                             next_irq;
   reg                             mapped;

   wire                            load_rd;
   wire                            wr_stb;
   wire [31:0]                     legal_events;
   wire [31:0]                     hits;
   wire [4:0]                      hit_pos;
   wire                            hit_any;
   wire                            wr_rate_en;
   wire                            wr_attr;
   wire                            wr_irq_clr;
   wire                            wr_irq_en;
   wire                            unlock_wr;
   wire                            capture_go;
   wire                            field_wr;
   wire [31:0]                     attr_word;
   wire [31:0]                     next_err_detect;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // True for any offset that the bank answers
   function is_mapped;
      input [23:0] addr;
      begin
         is_mapped = (addr == `PERC_OFS_RATE_EN)    ||
                     (addr == `PERC_OFS_ATTR_CAPT)  ||
                     (addr == `PERC_OFS_IRQ_STATUS) ||
                     (addr == `PERC_OFS_IRQ_CLEAR)  ||
                     (addr == `PERC_OFS_IRQ_ENABLE);
      end
   endfunction

   // Write strobe for one register
   function wr_hit;
      input        stb;
      input [23:0] addr;
      input [23:0] ofs;
      begin
         wr_hit = stb && (addr == ofs);
      end
   endfunction

   // Decode of the current bus address
   always @* begin
      mapped = is_mapped(paddr_i);
   end

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   // One wait state, registered ready and error; the fixed wait gives
   // the read mux a full cycle and keeps ready off any long path
   perc_apb_slave u_apb (
      .mclk_i    (mclk_i),
      .rstn_i    (rstn_i),
      .psel_i    (psel_i),
      .penable_i (penable_i),
      .pwrite_i  (pwrite_i),
      .mapped_i  (mapped),
      .pready_o  (pready_o),
      .pslverr_o (pslverr_o),
      .load_rd_o (load_rd),
      .wr_stb_o  (wr_stb)
   );

   // Per-register write strobes
   assign wr_rate_en = wr_hit(wr_stb, paddr_i, `PERC_OFS_RATE_EN);
   assign wr_attr    = wr_hit(wr_stb, paddr_i, `PERC_OFS_ATTR_CAPT);
   assign wr_irq_clr = wr_hit(wr_stb, paddr_i, `PERC_OFS_IRQ_CLEAR);
   assign wr_irq_en  = wr_hit(wr_stb, paddr_i, `PERC_OFS_IRQ_ENABLE);

   // ----------------------------------------------------------------
   // Error gating
   // ----------------------------------------------------------------
   // Only error classes with an enable bit can ever qualify; reserved
   // positions are dropped here so that neither the counter feed nor
   // the status register can ever show them
   assign legal_events = err_event_i & `PERC_EN_WMASK;

   // An event counts only with its enable bit set
   assign hits = legal_events & rate_en;

   // Lowest enabled error wins the capture slot
   perc_err_encode u_enc (
      .hits_i (hits),
      .pos_o  (hit_pos),
      .any_o  (hit_any)
   );

   // ----------------------------------------------------------------
   // Error rate enable register
   // ----------------------------------------------------------------
   // Writable classes: bit 0, bits 9-17, bits 26-31; the rest stay 0
   always @* begin
      next_rate_en = rate_en;
      if (wr_rate_en) begin
         next_rate_en = pwdata_i & `PERC_EN_WMASK;
      end
   end

   // Enable register
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         rate_en <= `PERC_EN_RESET;
      end else begin
         rate_en <= next_rate_en;
      end
   end

   // ----------------------------------------------------------------
   // Error rate counter feed
   // ----------------------------------------------------------------
   // Pulse and hit vector to the rate counter, also while locked, so
   // that a held capture never hides a burst from the counter
   always @* begin
      next_rate_inc  = hit_any;
      next_rate_hits = hits;
   end

   // Counter feed registers
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         rate_inc  <= 1'b0;
         rate_hits <= 32'h0000_0000;
      end else begin
         rate_inc  <= next_rate_inc;
         rate_hits <= next_rate_hits;
      end
   end

   // ----------------------------------------------------------------
   // Attribute capture
   // ----------------------------------------------------------------
   // A zero written to the valid bit releases the lock
   assign unlock_wr  = wr_attr & ~pwdata_i[`PERC_VALID_BIT];

   // Capture when unlocked, or when unlocking in this very cycle;
   // a new error in the clearing cycle is therefore kept
   assign capture_go = hit_any & (~capt_valid | unlock_wr);

   // Software may rewrite the fields only while the bank is unlocked,
   // or with the very write that unlocks it
   assign field_wr   = wr_attr & (~capt_valid | unlock_wr);

   // Fields load from hardware on capture, else from software while
   // unlocked or with the write that unlocks it; a locked bank ignores other field writes
   always @* begin
      next_info_type  = info_type;
      next_err_type   = err_type;
      next_impl_info  = impl_info;
      next_capt_valid = capt_valid;
      if (capture_go) begin
         next_info_type  = cap_info_type_i;
         next_err_type   = hit_pos;
         next_impl_info  = cap_impl_i;
         next_capt_valid = 1'b1;
      end else if (field_wr) begin
         next_info_type  = pwdata_i[`PERC_INFO_MSB:`PERC_INFO_LSB];
         next_err_type   = pwdata_i[`PERC_ETYPE_MSB:`PERC_ETYPE_LSB];
         next_impl_info  = pwdata_i[`PERC_IMPL_MSB:`PERC_IMPL_LSB];
         if (unlock_wr) begin
            next_capt_valid = 1'b0;
         end
      end
   end

   // Field registers; software setting bit 31 never sets valid
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         info_type  <= `PERC_INFO_RESET;
         err_type   <= `PERC_ETYPE_RESET;
         impl_info  <= `PERC_IMPL_RESET;
         capt_valid <= 1'b0;
      end else begin
         info_type  <= next_info_type;
         err_type   <= next_err_type;
         impl_info  <= next_impl_info;
         capt_valid <= next_capt_valid;
      end
   end

   // One-cycle strobe telling the capture data registers to load
   always @* begin
      next_capture_load = capture_go;
   end

   // Strobe register
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         capture_load <= 1'b0;
      end else begin
         capture_load <= next_capture_load;
      end
   end

   // Assembled attribute word, reserved bits 28-30 read zero
   assign attr_word = {capt_valid, 3'h0, impl_info, err_type, info_type};

   // ----------------------------------------------------------------
   // Error detect status and interrupt
   // ----------------------------------------------------------------
   // Sticky per class at the enable bit positions; set beats clear,
   // so an error in the clearing cycle is never lost
   assign next_err_detect = (err_detect & ~({32{wr_irq_clr}} & pwdata_i))
                            | legal_events;

   // Next enable and level; the level uses the new status and enable
   // so that it moves on the same edge as the status it reflects
   always @* begin
      next_irq_en = irq_en;
      if (wr_irq_en) begin
         next_irq_en = pwdata_i & `PERC_EN_WMASK;
      end
      next_irq = |(next_err_detect & next_irq_en);
   end

   // Detect, enable and interrupt level
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         err_detect <= `PERC_IRQ_RESET;
         irq_en     <= `PERC_IRQ_RESET;
         irq        <= 1'b0;
      end else begin
         err_detect <= next_err_detect;
         irq_en     <= next_irq_en;
         irq        <= next_irq;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Read data selection, clear register and unmapped read zero
   always @* begin
      case (paddr_i)
         `PERC_OFS_RATE_EN:    next_rd_data = rate_en;
         `PERC_OFS_ATTR_CAPT:  next_rd_data = attr_word;
         `PERC_OFS_IRQ_STATUS: next_rd_data = err_detect;
         `PERC_OFS_IRQ_ENABLE: next_rd_data = irq_en;
         default:              next_rd_data = `PERC_RDATA_RESET;
      endcase
   end

   // Read data registered in the wait cycle; the word reflects state
   // one cycle before ready, so a capture in the ready cycle shows on
   // the next read
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         rd_data <= `PERC_RDATA_RESET;
      end else if (load_rd) begin
         rd_data <= pwrite_i ? `PERC_RDATA_RESET : next_rd_data;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Every output comes straight from a register
   assign prdata_o       = rd_data;
   assign rate_inc_o     = rate_inc;
   assign rate_hits_o    = rate_hits;
   assign capture_lock_o = capt_valid;
   assign capture_load_o = capture_load;
   assign irq_o          = irq;

endmodule
`default_nettype wire

// ==== rtl/perc_regs.vh ====
// Register map, field positions and reset values of the per-port
// error rate enable and attribute capture bank.
// Assumes byte addresses on a 24-bit APB address with 32-bit words.
`ifndef PERC_REGS_VH
`define PERC_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PERC_ADDR_W            24
`define PERC_OFS_RATE_EN       24'h00_2044
`define PERC_OFS_ATTR_CAPT     24'h00_2048
`define PERC_OFS_IRQ_STATUS    24'h00_2070
`define PERC_OFS_IRQ_CLEAR     24'h00_2074
`define PERC_OFS_IRQ_ENABLE    24'h00_2078

// ----------------------------------------------------------------
// Error rate enable layout
// ----------------------------------------------------------------
`define PERC_EN_WMASK          32'hFC03_FE01
`define PERC_EN_RESET          32'h0000_0000
`define PERC_BIT_IMPL          0
`define PERC_BIT_BAD_CRC       13
`define PERC_BIT_FRAME_TOGGLE  28

// ----------------------------------------------------------------
// Attribute capture layout
// ----------------------------------------------------------------
`define PERC_INFO_LSB          0
`define PERC_INFO_MSB          2
`define PERC_ETYPE_LSB         3
`define PERC_ETYPE_MSB         7
`define PERC_IMPL_LSB          8
`define PERC_IMPL_MSB          27
`define PERC_VALID_BIT         31
`define PERC_INFO_PACKET       3'h0
`define PERC_INFO_SHORT_CS     3'h2
`define PERC_INFO_LONG_CS      3'h3
`define PERC_INFO_IMPL         3'h4
`define PERC_INFO_SBIT         3'h6
`define PERC_INFO_RESET        3'h0
`define PERC_ETYPE_RESET       5'h00
`define PERC_IMPL_RESET        20'h0_0000

// ----------------------------------------------------------------
// Interrupt bank
// ----------------------------------------------------------------
`define PERC_IRQ_RESET         32'h0000_0000
`define PERC_RDATA_RESET       32'h0000_0000

`endif

// ==== rtl/perc_apb_slave.v ====
// APB handshake for the error capture bank: one wait state per
// transfer, registered ready and error answer.
// Assumes an APB master on the same clock as the bank.
`timescale 1ns/100ps
`default_nettype none
`include "perc_regs.vh"

module perc_apb_slave (
   input  wire                     mclk_i,
   input  wire                     rstn_i,
   input  wire                     psel_i,
   input  wire                     penable_i,
   input  wire                     pwrite_i,
   input  wire                     mapped_i,
   output reg                      pready_o,
   output reg                      pslverr_o,
   output wire                     load_rd_o,
   output wire                     wr_stb_o
);

   // ----------------------------------------------------------------
   // Strobes
   // ----------------------------------------------------------------
   // Read data loads in the wait cycle; a write lands with ready
   assign load_rd_o = psel_i & penable_i & ~pready_o;
   assign wr_stb_o  = psel_i & penable_i & pready_o & pwrite_i & mapped_i;

   // Ready pulses one cycle after the access phase opens
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= load_rd_o;
         pslverr_o <= load_rd_o & ~mapped_i;
      end
   end

endmodule
`default_nettype wire

// ==== rtl/perc_err_encode.v ====
// Encoder that turns a vector of enabled error hits into the bit
// position of the lowest one set.
// Assumes the caller qualifies the result with a hit-present flag.
`timescale 1ns/100ps
`default_nettype none

module perc_err_encode (
   input  wire [31:0]              hits_i,
   output wire [4:0]               pos_o,
   output wire                     any_o
);

   // ----------------------------------------------------------------
   // Lowest set bit
   // ----------------------------------------------------------------
   function [4:0] lowest_bit;
      input [31:0] vec;
      integer      i;
      begin
         lowest_bit = 5'h00;
         for (i = 31; i >= 0; i = i - 1) begin
            if (vec[i]) begin
               lowest_bit = i[4:0];
            end
         end
      end
   endfunction

   // Position and presence
   assign pos_o = lowest_bit(hits_i);
   assign any_o = |hits_i;

endmodule
`default_nettype wire

// ==== tb/perc_chk.sv ====
// Port-level assertions for the error capture bank.
// Assumes it is bound into perc_top on the one system clock.
`timescale 1ns/100ps
`default_nettype none
`include "perc_regs.vh"
module perc_chk (
   input wire logic        mclk_i,
   input wire logic        rstn_i,
   input wire logic [23:0] paddr_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic [31:0] err_event_i,
   input wire logic        rate_inc_o,
   input wire logic [31:0] rate_hits_o,
   input wire logic        capture_lock_o,
   input wire logic        capture_load_o
);
   // Completed write of zero to the capture valid bit
   wire unlock_wr = psel_i && penable_i && pwrite_i && pready_o
                    && paddr_i == `PERC_OFS_ATTR_CAPT && !pwdata_i[31];
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   a_hits_enabled: assert property ((rate_hits_o & ~($past(err_event_i) & `PERC_EN_WMASK)) == 0)
      else $error("hit reported for an absent or reserved class");
   a_inc_any_hit: assert property (rate_inc_o == (rate_hits_o != 0))
      else $error("rate pulse disagrees with hit vector");
   a_load_needs_hit: assert property (capture_load_o |-> rate_inc_o)
      else $error("capture without an enabled error");
   a_load_sets_lock: assert property (capture_load_o |-> capture_lock_o)
      else $error("capture left valid bit low");
   a_lock_from_load: assert property ($rose(capture_lock_o) |-> capture_load_o)
      else $error("valid bit rose without capture");
   a_unlock_by_write: assert property ($fell(capture_lock_o) |-> $past(unlock_wr))
      else $error("valid bit fell without a clearing write");
   a_locked_no_load: assert property (capture_lock_o && !unlock_wr |=> !capture_load_o)
      else $error("capture overwritten while locked");
   a_ready_wait: assert property (psel_i && !penable_i |-> ##2 pready_o)
      else $error("ready not given after one wait state");
   a_err_with_ready: assert property (pslverr_o |-> pready_o)
      else $error("error answer outside ready cycle");
   c_load: cover property (capture_load_o);
   c_unlock: cover property ($fell(capture_lock_o));
   c_slverr: cover property (pslverr_o);
endmodule
bind perc_top perc_chk perc_chk_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .paddr_i(paddr_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .err_event_i(err_event_i),
   .rate_inc_o(rate_inc_o), .rate_hits_o(rate_hits_o), .capture_lock_o(capture_lock_o),
   .capture_load_o(capture_load_o));
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the error capture bank with a behavioural model.
// Assumes the bank answers APB within a bounded wait.
`timescale 1ns/100ps
`default_nettype none
`include "perc_regs.vh"
module tb_top;
   logic        mclk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [23:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, err_event_i = 0, prdata_o, rate_hits_o;
   logic [2:0]  cap_info_type_i = 0;
   logic [19:0] cap_impl_i = 0;
   logic        pready_o, pslverr_o, rate_inc_o, capture_lock_o, capture_load_o, irq_o;
   logic [31:0] en_m, attr_m, st_m, ie_m, exp_hits, rd;
   logic        exp_load, er, wr, cap, ev_on = 0;
   integer      seed = 29, mismatches = 0, compares = 0, i;
   logic [2:0]  infos [0:4] = '{`PERC_INFO_PACKET, `PERC_INFO_SHORT_CS, `PERC_INFO_LONG_CS,
                                `PERC_INFO_IMPL, `PERC_INFO_SBIT};
   // Clock
   always #50 mclk_i = ~mclk_i;
   perc_top perc_top_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .paddr_i(paddr_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .err_event_i(err_event_i),
      .cap_info_type_i(cap_info_type_i), .cap_impl_i(cap_impl_i), .rate_inc_o(rate_inc_o),
      .rate_hits_o(rate_hits_o), .capture_lock_o(capture_lock_o),
      .capture_load_o(capture_load_o), .irq_o(irq_o));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic [4:0] lowest(input [31:0] v);
      integer k;
      lowest = 0;
      for (k = 31; k >= 0; k--) if (v[k]) lowest = k[4:0];
   endfunction
   task automatic check(input string n, input [31:0] e, input [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run;
      $display("Compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // One APB transfer, holding the request until ready is sampled
   task automatic apb(input logic w, input [23:0] a, input [31:0] d);
      integer n;
      psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge mclk_i) penable_i <= 1;
      n = 0;
      do begin @(posedge mclk_i); n++; end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) begin mismatches++; complete_run; end
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 0; penable_i <= 0;
      @(posedge mclk_i);
   endtask
   task automatic rchk(input [23:0] a, input [31:0] e, input string n);
      apb(0, a, 32'h0000_0000);
      check(n, e, rd);
   endtask
   task automatic irq_chk;
      repeat (2) @(posedge mclk_i);
      check("irq", {31'h0, |(st_m & ie_m)}, {31'h0, irq_o});
   endtask
   // ----------------------------------------------------------------
   // Model of enable, capture, status and interrupt enable
   // ----------------------------------------------------------------
   always @(posedge mclk_i) begin
      wr = psel_i && penable_i && pwrite_i && pready_o === 1'b1;
      cap = (err_event_i & en_m) != 0 && (!attr_m[31] ||
            wr && paddr_i == `PERC_OFS_ATTR_CAPT && !pwdata_i[31]);
      if (!rstn_i) begin
         en_m <= 0; attr_m <= 0; st_m <= 0; ie_m <= 0; exp_hits <= 0; exp_load <= 0;
      end else begin
         exp_hits <= err_event_i & en_m;
         exp_load <= cap;
         st_m <= st_m & ~((wr && paddr_i == `PERC_OFS_IRQ_CLEAR) ? pwdata_i : 32'h0)
                 | err_event_i & `PERC_EN_WMASK;
         if (wr && paddr_i == `PERC_OFS_RATE_EN) en_m <= pwdata_i & `PERC_EN_WMASK;
         if (wr && paddr_i == `PERC_OFS_IRQ_ENABLE) ie_m <= pwdata_i & `PERC_EN_WMASK;
         if (wr && paddr_i == `PERC_OFS_ATTR_CAPT && (!attr_m[31] || !pwdata_i[31]))
            attr_m <= {4'h0, pwdata_i[27:0]};
         if (cap) attr_m <= {4'h8, cap_impl_i, lowest(err_event_i & en_m), cap_info_type_i};
      end
   end
   // Per-cycle comparison of the rate feed and capture outputs
   always @(negedge mclk_i) if (rstn_i) begin
      check("rate_hits", exp_hits, rate_hits_o);
      check("rate_inc", {31'h0, exp_hits != 0}, {31'h0, rate_inc_o});
      check("capture_load", {31'h0, exp_load}, {31'h0, capture_load_o});
      check("capture_lock", {31'h0, attr_m[31]}, {31'h0, capture_lock_o});
   end
   // Sparse random error events with legal info types
   always @(posedge mclk_i) begin
      err_event_i <= ev_on ? $random(seed) & $random(seed) & $random(seed) : 32'h0;
      cap_info_type_i <= infos[{$random(seed)} % 5];
      cap_impl_i <= 20'($random(seed));
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge mclk_i);
      rstn_i <= 1;
      @(posedge mclk_i);
      rchk(`PERC_OFS_RATE_EN, `PERC_EN_RESET, "enable reset");
      rchk(`PERC_OFS_ATTR_CAPT, 32'h0000_0000, "capture reset");
      apb(1, `PERC_OFS_RATE_EN, 32'hFFFF_FFFF);
      rchk(`PERC_OFS_RATE_EN, 32'hFC03_FE01, "enable mask");
      check("mapped error", 32'h0000_0000, {31'h0, er});
      rchk(24'h00_2000, 32'h0000_0000, "unmapped data");
      check("unmapped error", 32'h0000_0001, {31'h0, er});
      for (i = 0; i < 24; i++) begin
         apb(1, `PERC_OFS_RATE_EN, (i < 4) ? 32'hFFFF_FFFF : $random(seed));
         ev_on <= 1;
         repeat (8) @(posedge mclk_i);
         apb(1, `PERC_OFS_ATTR_CAPT, $random(seed));
         ev_on <= 0;
         repeat (3) @(posedge mclk_i);
         rchk(`PERC_OFS_ATTR_CAPT, attr_m, "capture");
         rchk(`PERC_OFS_IRQ_STATUS, st_m, "status");
         rchk(`PERC_OFS_IRQ_CLEAR, 32'h0000_0000, "clear read");
         irq_chk;
         apb(1, `PERC_OFS_IRQ_ENABLE, $random(seed));
         irq_chk;
         apb(1, `PERC_OFS_IRQ_CLEAR, $random(seed));
         rchk(`PERC_OFS_IRQ_STATUS, st_m, "status clear");
         irq_chk;
      end
      complete_run;
   end
endmodule
`default_nettype wire
